// *** include/scan_entry_consts.svh ***
// constants for the scan-list entry register bank
`ifndef SCAN_ENTRY_CONSTS_SVH
`define SCAN_ENTRY_CONSTS_SVH
`define IDX_ENTRY_LOW  6'h10
`define IDX_ENTRY_HIGH 6'h12
`define IDX_CTRL       6'h14
`define IDX_STATUS     6'h15
`define ADDR_IDX       7:2
`define HI_TYPE        14:12
`define HI_GROUP       5:4
`define HI_CHAN        3:0
`define LO_LAST        15
`define LO_TRIG        12
`define LO_DITHER      9
`define LO_UNIP        8
`define LO_GAIN        2:0
`define CTRL_CLEAR     0
`define CTRL_START     1
`define ST_BUSY        0
`define ST_OVF         1
`define ST_BAD_TYPE    2
`define ST_COUNT       15:8
`define ST_INDEX       23:16
`define TYPE_CAL       3'h0
`define TYPE_PAIR      3'h1
`define TYPE_SENSE     3'h2
`define TYPE_GROUND    3'h3
`define TYPE_GHOST     3'h7
`define NODE_OUT_GND   5'h10
`define NODE_IN_GND    5'h11
`define NODE_REF5      5'h12
`define NODE_CONV0     5'h13
`define NODE_CONV1     5'h14
`define NODE_SENSE     5'h15
`define NODE_NONE      5'h1f
`define PAIR_NEG_OFS   5'h08
`define CLK_NS         20
`define SETTLE_NS      1000
`define CONV_NS        2000
`define SCAN_DEPTH     16
`endif

// *** include/scan_entry_pkg.sv ***
// types shared by the scan-list entry register bank
`include "scan_entry_consts.svh"
package scan_entry_pkg;
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avs_req_t;
	typedef struct packed {
		logic       last;
		logic       gen_trig;
		logic       dither;
		logic       unipolar;
		logic [2:0] gain;
		logic [2:0] rtype;
		logic [1:0] group;
		logic [3:0] chan;
	} entry_t;
	typedef struct packed {
		logic [4:0] pos;
		logic [4:0] neg;
	} route_t;
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_LOAD, SEQ_SETTLE, SEQ_CONVERT, SEQ_NEXT
	} seq_t;
endpackage

// *** rtl/scan_entry_bank.sv ***
// scan-list entry store, Avalon-MM slave and input mux sequencer
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "scan_entry_consts.svh"
module scan_entry_bank #(
	parameter int DEPTH      = `SCAN_DEPTH,
	parameter int SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS,
	parameter int CONV_CYC   = (`CONV_NS + `CLK_NS - 1) / `CLK_NS
) (
	input  wire logic        CLK_SYS_IN,
	input  wire logic        SRST_IN,
	input  wire logic [7:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	output logic      [2:0]  RES_TYPE_OUT,
	output logic      [1:0]  GROUP_OUT,
	output logic      [3:0]  CHAN_OUT,
	output logic      [4:0]  POS_NODE_OUT,
	output logic      [4:0]  NEG_NODE_OUT,
	output logic      [2:0]  GAIN_OUT,
	output logic             UNIPOLAR_OUT,
	output logic             DITHER_OUT,
	output logic             GEN_TRIG_N_OUT,
	output logic             CONVERT_OUT,
	output logic             FIFO_SHIFT_OUT
);
	localparam int IW = $clog2(DEPTH);
	localparam int CW = IW + 1;
	localparam int TW = $clog2(SETTLE_CYC + CONV_CYC + 1);

	typedef struct packed {
		scan_entry_pkg::entry_t [DEPTH-1:0] mem;
		logic [15:0]                low_hold;
		logic [15:0]                up_hold;
		logic [CW-1:0]              count;
		logic [IW-1:0]              wr_ptr;
		logic [IW-1:0]              rd_ptr;
		logic                       ovf;
		logic                       bad_type;
		scan_entry_pkg::seq_t       seq;
		logic [TW-1:0]              timer;
		logic                       skip;
		logic                       cur_last;
		logic                       cur_trig;
		logic                       wait_r;
		logic [31:0]                rdata;
		logic [2:0]                 rtype;
		logic [1:0]                 group;
		logic [3:0]                 chan;
		logic [4:0]                 pos;
		logic [4:0]                 neg;
		logic [2:0]                 gain;
		logic                       unipolar;
		logic                       dither;
		logic                       gen_trig_n;
		logic                       convert;
		logic                       shift;
	} state_t;

	state_t                   r_reg;
	state_t                   r_next;
	scan_entry_pkg::avs_req_t req;
	scan_entry_pkg::entry_t   cur;
	scan_entry_pkg::route_t   rt;
	logic [5:0]               idx;
	logic [15:0]              merged;
	logic                     taken;
	logic                     clr;
	logic                     invalid;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic scan_entry_pkg::route_t route(input logic [2:0] t,
		input logic [3:0] c);
		scan_entry_pkg::route_t v;
		v.pos = `NODE_NONE;
		v.neg = `NODE_NONE;
		unique case (t)
		`TYPE_CAL: begin
			if (!c[3]) begin
				unique case (c[2:0])
				3'h0: v = '{`NODE_OUT_GND, `NODE_OUT_GND};
				3'h1: v = '{`NODE_OUT_GND, `NODE_IN_GND};
				3'h2: v = '{`NODE_CONV0, `NODE_OUT_GND};
				3'h3: v = '{`NODE_CONV1, `NODE_OUT_GND};
				3'h4: v = '{`NODE_REF5, `NODE_REF5};
				3'h5: v = '{`NODE_REF5, `NODE_IN_GND};
				3'h6: v = '{`NODE_CONV0, `NODE_REF5};
				3'h7: v = '{`NODE_CONV1, `NODE_REF5};
				endcase
			end
		end
		`TYPE_PAIR: begin
			if (!c[3]) begin
				v.pos = {1'b0, c};
				v.neg = {1'b0, c} + `PAIR_NEG_OFS;
			end
		end
		`TYPE_SENSE: v = '{{1'b0, c}, `NODE_SENSE};
		`TYPE_GROUND: v = '{{1'b0, c}, `NODE_IN_GND};
		default: v = '{`NODE_NONE, `NODE_NONE};
		endcase
		route = v;
	endfunction

	assign req = '{AVS_ADDRESS_IN, AVS_READ_IN, AVS_WRITE_IN,
		AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN};
	assign idx = req.address[`ADDR_IDX];
	assign cur = r_reg.mem[r_reg.rd_ptr];
	assign rt = route(cur.rtype, cur.chan);
	assign invalid = cur.rtype[2] && (cur.rtype != `TYPE_GHOST);
	// write lands on the edge where waitrequest is seen low
	assign taken = req.write && !r_reg.wait_r;
	assign clr = taken && idx == `IDX_CTRL
		&& req.writedata[`CTRL_CLEAR];
	assign merged = merge16(idx == `IDX_ENTRY_HIGH ? r_reg.up_hold
		: r_reg.low_hold, req.writedata, req.byteenable);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.shift = 1'b0;
		// one wait cycle per request, then release
		r_next.wait_r = !((req.read || req.write) && r_reg.wait_r);
		if (req.read && r_reg.wait_r) begin
			r_next.rdata = '0;
			if (idx == `IDX_STATUS) begin
				r_next.rdata[`ST_BUSY] = r_reg.seq != scan_entry_pkg::SEQ_IDLE;
				r_next.rdata[`ST_OVF] = r_reg.ovf;
				r_next.rdata[`ST_BAD_TYPE] = r_reg.bad_type;
				r_next.rdata[`ST_COUNT] = 8'(r_reg.count);
				r_next.rdata[`ST_INDEX] = 8'(r_reg.rd_ptr);
			end
		end

		// sequencer steps through stored entries in order
		unique case (r_reg.seq)
		scan_entry_pkg::SEQ_IDLE: begin
		end
		scan_entry_pkg::SEQ_LOAD: begin
			// ghost and invalid types keep the slot but never acquire
			r_next.skip = cur.rtype == `TYPE_GHOST || invalid;
			r_next.rtype = cur.rtype;
			r_next.group = cur.rtype == `TYPE_CAL ? 2'h0 : cur.group;
			r_next.chan = cur.rtype == `TYPE_GHOST ? 4'h0 : cur.chan;
			r_next.pos = rt.pos;
			r_next.neg = rt.neg;
			r_next.gain = cur.gain;
			r_next.unipolar = cur.unipolar;
			r_next.dither = cur.dither;
			r_next.cur_last = cur.last;
			r_next.cur_trig = cur.gen_trig;
			r_next.timer = '0;
			r_next.seq = scan_entry_pkg::SEQ_SETTLE;
		end
		scan_entry_pkg::SEQ_SETTLE: begin
			r_next.timer = r_reg.timer + 1'b1;
			if (r_reg.timer == TW'(SETTLE_CYC - 1)) begin
				r_next.timer = '0;
				r_next.convert = !r_reg.skip;
				r_next.gen_trig_n = !(r_reg.cur_trig && !r_reg.skip);
				r_next.seq = scan_entry_pkg::SEQ_CONVERT;
			end
		end
		scan_entry_pkg::SEQ_CONVERT: begin
			// mux fields are untouched here, so they hold
			r_next.timer = r_reg.timer + 1'b1;
			if (r_reg.timer == TW'(CONV_CYC - 1)) begin
				r_next.convert = 1'b0;
				r_next.gen_trig_n = 1'b1;
				r_next.shift = !r_reg.skip;
				r_next.seq = scan_entry_pkg::SEQ_NEXT;
			end
		end
		scan_entry_pkg::SEQ_NEXT: begin
			r_next.rd_ptr = (r_reg.rd_ptr == IW'(r_reg.count - 1'b1))
				? '0 : r_reg.rd_ptr + 1'b1;
			// a flagged entry ends this scan; next start resumes after it
			r_next.seq = r_reg.cur_last ? scan_entry_pkg::SEQ_IDLE
				: scan_entry_pkg::SEQ_LOAD;
		end
		endcase

		if (taken) begin
			unique case (idx)
			`IDX_ENTRY_HIGH: r_next.up_hold = merged;
			`IDX_ENTRY_LOW: begin
				r_next.low_hold = merged;
				if (r_reg.count == CW'(DEPTH)) begin
					r_next.ovf = 1'b1;
				end else begin
					r_next.mem[r_reg.wr_ptr] = '{merged[`LO_LAST],
						merged[`LO_TRIG], merged[`LO_DITHER],
						merged[`LO_UNIP], merged[`LO_GAIN],
						r_reg.up_hold[`HI_TYPE], r_reg.up_hold[`HI_GROUP],
						r_reg.up_hold[`HI_CHAN]};
					r_next.wr_ptr = r_reg.wr_ptr + 1'b1;
					r_next.count = r_reg.count + 1'b1;
				end
			end
			`IDX_CTRL: begin
				if (!req.writedata[`CTRL_CLEAR] && req.writedata[`CTRL_START]
					&& r_reg.seq == scan_entry_pkg::SEQ_IDLE
					&& r_reg.count != '0) begin
					r_next.seq = scan_entry_pkg::SEQ_LOAD;
				end
			end
			default: begin
			end
			endcase
		end

		if (clr) begin
			r_next.mem = '0;
			r_next.count = '0;
			r_next.wr_ptr = '0;
			r_next.rd_ptr = '0;
			r_next.ovf = 1'b0;
			r_next.bad_type = 1'b0;
			r_next.seq = scan_entry_pkg::SEQ_IDLE;
			r_next.convert = 1'b0;
			r_next.gen_trig_n = 1'b1;
			r_next.shift = 1'b0;
		end
		// an invalid type seen as the clear lands is still reported
		if (r_reg.seq == scan_entry_pkg::SEQ_LOAD && invalid) begin
			r_next.bad_type = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (SRST_IN) begin
			r_reg <= '0;
			r_reg.seq <= scan_entry_pkg::SEQ_IDLE;
			r_reg.wait_r <= 1'b1;
			r_reg.gen_trig_n <= 1'b1;
			r_reg.pos <= `NODE_NONE;
			r_reg.neg <= `NODE_NONE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign AVS_READDATA_OUT = r_reg.rdata;
	assign AVS_WAITREQUEST_OUT = r_reg.wait_r;
	assign RES_TYPE_OUT = r_reg.rtype;
	assign GROUP_OUT = r_reg.group;
	assign CHAN_OUT = r_reg.chan;
	assign POS_NODE_OUT = r_reg.pos;
	assign NEG_NODE_OUT = r_reg.neg;
	assign GAIN_OUT = r_reg.gain;
	assign UNIPOLAR_OUT = r_reg.unipolar;
	assign DITHER_OUT = r_reg.dither;
	assign GEN_TRIG_N_OUT = r_reg.gen_trig_n;
	assign CONVERT_OUT = r_reg.convert;
	assign FIFO_SHIFT_OUT = r_reg.shift;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (SRST_IN);

	upper_store_a: assert property (
		taken && idx == `IDX_ENTRY_HIGH && req.byteenable[1:0] == 2'h3
		|=> r_reg.up_hold == $past(req.writedata[15:0]))
		else $error("upper word not stored");
	entry_merge_a: assert property (
		taken && idx == `IDX_ENTRY_LOW && !clr && r_reg.count != CW'(DEPTH)
		|=> r_reg.count == $past(r_reg.count) + 1'b1
			&& r_reg.mem[$past(r_reg.wr_ptr)].chan == $past(r_reg.up_hold[3:0]))
		else $error("entry not committed");
	clear_all_a: assert property (clr |=> r_reg.count == '0
		&& r_reg.seq == scan_entry_pkg::SEQ_IDLE && !CONVERT_OUT)
		else $error("clear left entries");
	ghost_quiet_a: assert property (
		RES_TYPE_OUT == `TYPE_GHOST && r_reg.seq == scan_entry_pkg::SEQ_CONVERT
		|-> !CONVERT_OUT && POS_NODE_OUT == `NODE_NONE && CHAN_OUT == 4'h0)
		else $error("ghost entry acquired");
	ghost_shift_a: assert property (FIFO_SHIFT_OUT
		|-> RES_TYPE_OUT != `TYPE_GHOST && !RES_TYPE_OUT[2] && $past(CONVERT_OUT))
		else $error("ghost result shifted");
	cal_group_a: assert property (
		CONVERT_OUT && RES_TYPE_OUT == `TYPE_CAL |-> GROUP_OUT == 2'h0)
		else $error("cal group not zero");
	pair_route_a: assert property (
		CONVERT_OUT && RES_TYPE_OUT == `TYPE_PAIR && !CHAN_OUT[3]
		|-> NEG_NODE_OUT == POS_NODE_OUT + `PAIR_NEG_OFS)
		else $error("paired route wrong");
	single_route_a: assert property (
		CONVERT_OUT && RES_TYPE_OUT[2:1] == 2'h1
		|-> POS_NODE_OUT == {1'b0, CHAN_OUT} && NEG_NODE_OUT
			== (RES_TYPE_OUT[0] ? `NODE_IN_GND : `NODE_SENSE))
		else $error("single-ended route wrong");
	// only inside one conversion: the next entry may load new settings
	conv_hold_a: assert property (
		CONVERT_OUT && $past(CONVERT_OUT) |-> $stable({POS_NODE_OUT,
			NEG_NODE_OUT, RES_TYPE_OUT, GROUP_OUT, CHAN_OUT, GAIN_OUT}))
		else $error("mux moved in conversion");
	step_order_a: assert property (
		r_reg.seq == scan_entry_pkg::SEQ_NEXT && !r_reg.cur_last && !clr
		|=> r_reg.seq == scan_entry_pkg::SEQ_LOAD ##1 ($rose(r_reg.seq
			== scan_entry_pkg::SEQ_SETTLE) || $past(clr)))
		else $error("scan did not step");
	bus_answer_a: assert property ((req.read || req.write) && r_reg.wait_r
		|=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
		else $error("bus answer timing");
endmodule
`default_nettype wire

// *** verification/scan_entry_bank_test.sv ***
// self-checking bench for the scan-list entry register bank
`timescale 1ns/10ps
`default_nettype none
module scan_entry_bank_test;
	localparam int SETTLE = 2;
	localparam int CONV   = 3;
	localparam int DEPTH  = 4;
	logic        clk;
	logic        srst;
	logic [7:0]  address;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] readdata;
	logic        waitreq;
	logic [2:0]  rtype;
	logic [1:0]  grp;
	logic [3:0]  chan;
	logic [4:0]  pos;
	logic [4:0]  neg;
	logic [2:0]  gain;
	logic        unip;
	logic        dither;
	logic        trig_n;
	logic        conv;
	logic        shift;
	int          failures;
	int          comparisons;
	logic [31:0] q;

	scan_entry_bank #(.DEPTH(DEPTH), .SETTLE_CYC(SETTLE), .CONV_CYC(CONV)) u_dut (
		.CLK_SYS_IN         (clk),
		.SRST_IN            (srst),
		.AVS_ADDRESS_IN     (address),
		.AVS_READ_IN        (rd),
		.AVS_WRITE_IN       (wr),
		.AVS_WRITEDATA_IN   (wdata),
		.AVS_BYTEENABLE_IN  (be),
		.AVS_READDATA_OUT   (readdata),
		.AVS_WAITREQUEST_OUT(waitreq),
		.RES_TYPE_OUT       (rtype),
		.GROUP_OUT          (grp),
		.CHAN_OUT           (chan),
		.POS_NODE_OUT       (pos),
		.NEG_NODE_OUT       (neg),
		.GAIN_OUT           (gain),
		.UNIPOLAR_OUT       (unip),
		.DITHER_OUT         (dither),
		.GEN_TRIG_N_OUT     (trig_n),
		.CONVERT_OUT        (conv),
		.FIFO_SHIFT_OUT     (shift)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic is_rd, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		address <= a;
		rd <= is_rd;
		wr <= !is_rd;
		wdata <= d;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (waitreq !== 1'b0) begin
			failures++;
			wrap_up();
		end else begin
			r = readdata;
			@(posedge clk);
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b0, a, d, r);
	endtask

	// expected amplifier nodes {pos, neg} for a type and channel code
	function automatic logic [9:0] route(input logic [2:0] t,
			input logic [3:0] c);
		case (t)
			3'h0: begin
				case (c)
					4'h0: return {5'h10, 5'h10};
					4'h1: return {5'h10, 5'h11};
					4'h2: return {5'h13, 5'h10};
					4'h3: return {5'h14, 5'h10};
					4'h4: return {5'h12, 5'h12};
					4'h5: return {5'h12, 5'h11};
					4'h6: return {5'h13, 5'h12};
					4'h7: return {5'h14, 5'h12};
					default: return {5'h1f, 5'h1f};
				endcase
			end
			3'h1: return c[3] ? {5'h1f, 5'h1f} : {1'b0, c, 1'b0, c + 4'h8};
			3'h2: return {1'b0, c, 5'h15};
			3'h3: return {1'b0, c, 5'h11};
			default: return {5'h1f, 5'h1f};
		endcase
	endfunction

	// start one scan and watch it; the bound covers several entries
	task automatic scan(input logic [9:0] node, output int cv, output int sh,
			output int tg, output int bad);
		cv = 0;
		sh = 0;
		tg = 0;
		bad = 0;
		wr_reg(8'h50, 32'h2);
		repeat (60) begin
			@(negedge clk);
			if (conv === 1'b1) begin
				cv++;
				if ({pos, neg} !== node) bad++;
				if (trig_n === 1'b0) tg++;
			end
			if (shift === 1'b1) sh++;
		end
	endtask

	task automatic entry(input logic [2:0] t, input logic [1:0] g,
			input logic [3:0] c, input logic [15:0] lo);
		int cv, sh, tg, bad;
		logic ok;
		ok = (t <= 3'h3);
		wr_reg(8'h50, 32'h1);
		wr_reg(8'h48, {16'h0, 1'b0, t, 6'h00, g, c});
		wr_reg(8'h40, {16'h0, lo});
		scan(route(t, c), cv, sh, tg, bad);
		chk(cv, ok ? CONV : 0);
		chk(sh, ok ? 1 : 0);
		chk(tg, (ok && lo[12]) ? CONV : 0);
		chk(bad, 0);
		chk({pos, neg}, route(t, c));
		chk(rtype, t);
		if (t == 3'h7) chk(chan, 4'h0);
		if (ok) chk({grp, chan}, {t == 3'h0 ? 2'h0 : g, c});
		chk({gain, unip, dither}, {lo[2:0], lo[8], lo[9]});
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int cv, sh, tg, bad;
		srst = 1'b1;
		address = 8'h00;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0;
		be = 4'hf;
		failures = 0;
		comparisons = 0;
		void'($urandom(63047));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk({waitreq, pos, neg, conv, shift, trig_n}, {1'b1, 10'h3ff, 3'b001});
		$display("test reset done");

		// write-only and unmapped places read back zero
		bus(1'b1, 8'h48, 32'h0, q);
		chk(q, 32'h0);
		wr_reg(8'hfc, 32'hffff);
		bus(1'b1, 8'hfc, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, 8'h54, 32'h0, q);
		chk(q[15:8], 8'h00);
		$display("test decode done");

		// every type against every channel code, random group and lower
		// cal and paired get only codes 0..7, the others all sixteen
		for (int i = 0; i < 128; i++) begin
			entry(i[2:0], 2'($urandom),
				{i[6] && i[2:1] != 2'h0, i[5:3]},
				16'h8000 | (16'($urandom) & 16'h1307));
		end
		$display("test table done");

		// held upper reused by two lower words, stepped in order
		wr_reg(8'h50, 32'h1);
		wr_reg(8'h48, {16'h0, 16'h1013});
		wr_reg(8'h40, 32'h0002);
		wr_reg(8'h40, 32'h8005);
		bus(1'b1, 8'h54, 32'h0, q);
		chk(q[15:8], 8'h02);
		scan(route(3'h1, 4'h3), cv, sh, tg, bad);
		chk(cv, CONV * 2);
		chk(sh, 2);
		chk(bad, 0);
		chk(gain, 3'h5);
		$display("test pairing done");

		// overflow, then clearing empties the store
		for (int i = 0; i <= DEPTH; i++) wr_reg(8'h40, 32'h8001);
		bus(1'b1, 8'h54, 32'h0, q);
		chk({q[15:8], q[1]}, {8'(DEPTH), 1'b1});
		wr_reg(8'h50, 32'h1);
		bus(1'b1, 8'h54, 32'h0, q);
		chk({q[15:8], q[1]}, 9'h000);
		scan(10'h0, cv, sh, tg, bad);
		chk(cv, 0);
		chk(sh, 0);
		$display("test clear done");
		wrap_up();
	end
endmodule
`default_nettype wire
